//--- core/psr_pkg.sv
// Package of addresses, subbank limits and reset values for the peripheral subbank register access block
`default_nettype none
package psr_pkg;

  // ****************************************************************
  // Bus and register widths
  // ****************************************************************
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 16;

  // ****************************************************************
  // Data-space map
  // ****************************************************************
  localparam logic [15:0] CORE_REGION_TOP       = 16'h001F;
  localparam logic [15:0] SER0_SUBBANK_PTR_ADDR = 16'h0038;
  localparam logic [15:0] SER0_SUBBANK_DAT_ADDR = 16'h0039;
  localparam logic [15:0] SER1_SUBBANK_PTR_ADDR = 16'h0048;
  localparam logic [15:0] SER1_SUBBANK_DAT_ADDR = 16'h0049;
  localparam logic [15:0] DMA_PRIO_CTRL_ADDR    = 16'h0054;
  localparam logic [15:0] DMA_SUBBANK_PTR_ADDR  = 16'h0055;
  localparam logic [15:0] DMA_SUBBANK_INC_ADDR  = 16'h0056;
  localparam logic [15:0] DMA_SUBBANK_FIX_ADDR  = 16'h0057;

  // ****************************************************************
  // Subbank extents
  // ****************************************************************
  localparam logic [15:0] SER_SUB_FIRST = 16'h0000;
  localparam logic [15:0] SER_SUB_LAST  = 16'h000E;
  localparam logic [15:0] DMA_SUB_FIRST = 16'h0000;
  localparam logic [15:0] DMA_SUB_LAST  = 16'h0027;
  localparam int unsigned SER_SUB_W     = 4;
  localparam int unsigned DMA_SUB_W     = 6;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [15:0] PTR_RESET       = 16'h0000;
  localparam logic [15:0] PRIO_CTRL_RESET = 16'h0000;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;

endpackage
`default_nettype wire

//--- core/psr_subbank_ptr.sv
// One subbank pointer register with optional post-increment and range check
`default_nettype none
module psr_subbank_ptr #(
  parameter logic [15:0] LAST = 16'h0000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Pointer write and advance
  input  wire logic        ptr_wr_i,
  input  wire logic        ptr_inc_i,
  input  wire logic [15:0] wdata_i,
  // Pointer state
  output logic      [15:0] ptr_o,
  output logic             in_range_o
);

  logic [15:0] ptr_q;

  // Pointer: direct write, else advance after an incrementing access
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ptr_q <= psr_pkg::PTR_RESET;
    end else if (ptr_wr_i) begin
      ptr_q <= wdata_i;
    end else if (ptr_inc_i) begin
      ptr_q <= ptr_q + 16'h0001;
    end
  end

  assign ptr_o      = ptr_q;
  assign in_range_o = (ptr_q <= LAST);

endmodule
`default_nettype wire

//--- core/psr_top.sv
// Peripheral memory-mapped register decode with serial port and DMA subbank access
// Notes on behaviour
// RL1 - Addresses up to 1Fh belong to the core; this block never claims them, though a read there still gets a zero-data rvalid pulse.
// RL2 - Each serial port has a directly addressed pointer at 38h and 48h.
// RL3 - Access at 39h or 49h reaches the register the port's pointer selects.
// RL4 - Serial subbanks decode subaddresses 00h to 0Eh, same encoding for both ports.
// RL5 - DMA priority and enable control sits directly at 54h, outside the subbank.
// RL6 - The DMA subbank pointer sits directly at 55h.
// RL7 - Access at 57h reaches the selected DMA register and leaves the pointer alone.
// RL8 - Access at 56h reaches the selected DMA register, then the pointer adds one.
// RL9 - Software uses 57h unless it wants successive registers in a run.
// RL10 - DMA subbank decodes subaddresses 00h to 27h.
// RL11 - Pointers and data are 16 bits; undecoded subaddresses ignore writes, read zero.
`default_nettype none
module psr_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Processor data-memory bus
  input  wire logic [15:0] bus_addr_i,
  input  wire logic [15:0] bus_wdata_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_rd_i,
  output logic             bus_hit_o,
  output logic      [15:0] bus_rdata_o,
  output logic             bus_rvalid_o,
  // Shared write data to the peripheral register files
  output logic      [15:0] per_wdata_o,
  // Serial port 0 subbank
  output logic      [3:0]  ser0_sub_addr_o,
  output logic             ser0_sub_wr_o,
  output logic             ser0_sub_rd_o,
  input  wire logic [15:0] ser0_sub_rdata_i,
  // Serial port 1 subbank
  output logic      [3:0]  ser1_sub_addr_o,
  output logic             ser1_sub_wr_o,
  output logic             ser1_sub_rd_o,
  input  wire logic [15:0] ser1_sub_rdata_i,
  // DMA subbank and direct control
  output logic      [5:0]  dma_sub_addr_o,
  output logic             dma_sub_wr_o,
  output logic             dma_sub_rd_o,
  input  wire logic [15:0] dma_sub_rdata_i,
  output logic      [15:0] dma_prio_ctrl_o
);

  // ****************************************************************
  // Address decode
  // ****************************************************************

  logic acc;
  logic in_periph;
  logic hit_s0_ptr;
  logic hit_s0_dat;
  logic hit_s1_ptr;
  logic hit_s1_dat;
  logic hit_prio;
  logic hit_d_ptr;
  logic hit_d_inc;
  logic hit_d_fix;
  logic hit_d_dat;

  // The core region bound is kept explicit, so a later map change
  // can never let this block claim a core register
  // Only addresses above the core region are decoded here
  assign acc        = bus_wr_i | bus_rd_i;
  assign in_periph  = (bus_addr_i > psr_pkg::CORE_REGION_TOP); // [RL1]
  assign hit_s0_ptr = in_periph && (bus_addr_i == psr_pkg::SER0_SUBBANK_PTR_ADDR); // [RL2]
  assign hit_s0_dat = in_periph && (bus_addr_i == psr_pkg::SER0_SUBBANK_DAT_ADDR); // [RL3]
  assign hit_s1_ptr = in_periph && (bus_addr_i == psr_pkg::SER1_SUBBANK_PTR_ADDR); // [RL2]
  assign hit_s1_dat = in_periph && (bus_addr_i == psr_pkg::SER1_SUBBANK_DAT_ADDR); // [RL3]
  assign hit_prio   = in_periph && (bus_addr_i == psr_pkg::DMA_PRIO_CTRL_ADDR); // [RL5]
  assign hit_d_ptr  = in_periph && (bus_addr_i == psr_pkg::DMA_SUBBANK_PTR_ADDR); // [RL6]
  assign hit_d_inc  = in_periph && (bus_addr_i == psr_pkg::DMA_SUBBANK_INC_ADDR); // [RL8]
  assign hit_d_fix  = in_periph && (bus_addr_i == psr_pkg::DMA_SUBBANK_FIX_ADDR); // [RL7]
  assign hit_d_dat  = hit_d_inc | hit_d_fix;

  assign bus_hit_o  = acc & (hit_s0_ptr | hit_s0_dat | hit_s1_ptr | hit_s1_dat |
                             hit_prio | hit_d_ptr | hit_d_dat);

  // ****************************************************************
  // Subbank pointers
  // ****************************************************************

  logic [15:0] s0_ptr;
  logic [15:0] s1_ptr;
  logic [15:0] d_ptr;
  logic        s0_ok;
  logic        s1_ok;
  logic        d_ok;

  // Pointers keep all 16 written bits, so software reads back what it wrote;
  // only the low bits select a register, and the range check guards the rest
  // Serial port 0 pointer, never advances
  psr_subbank_ptr #(
    .LAST       (psr_pkg::SER_SUB_LAST) // [RL4]
  ) u_ser0_ptr (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .ptr_wr_i   (bus_wr_i & hit_s0_ptr), // [RL2]
    .ptr_inc_i  (1'h0),
    .wdata_i    (bus_wdata_i),
    .ptr_o      (s0_ptr),
    .in_range_o (s0_ok)
  );

  // Serial port 1 pointer, same subaddress encoding as port 0
  // Port 1 shares the range limit of port 0, so both banks decode alike
  psr_subbank_ptr #(
    .LAST       (psr_pkg::SER_SUB_LAST) // [RL4]
  ) u_ser1_ptr (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .ptr_wr_i   (bus_wr_i & hit_s1_ptr), // [RL2]
    .ptr_inc_i  (1'h0),
    .wdata_i    (bus_wdata_i),
    .ptr_o      (s1_ptr),
    .in_range_o (s1_ok)
  );

  // DMA pointer, advances after any access through the incrementing port
  // It advances even past the last register, so a long run wraps the full pointer
  psr_subbank_ptr #(
    .LAST       (psr_pkg::DMA_SUB_LAST) // [RL10]
  ) u_dma_ptr (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .ptr_wr_i   (bus_wr_i & hit_d_ptr), // [RL6]
    .ptr_inc_i  (acc & hit_d_inc), // [RL8]
    .wdata_i    (bus_wdata_i),
    .ptr_o      (d_ptr),
    .in_range_o (d_ok)
  );

  // ****************************************************************
  // Routing to the peripheral register files
  // ****************************************************************

  // Subaddress comes straight from the pointer flops
  assign per_wdata_o     = bus_wdata_i;
  assign ser0_sub_addr_o = s0_ptr[psr_pkg::SER_SUB_W-1:0]; // [RL4]
  assign ser1_sub_addr_o = s1_ptr[psr_pkg::SER_SUB_W-1:0]; // [RL4]
  assign dma_sub_addr_o  = d_ptr[psr_pkg::DMA_SUB_W-1:0]; // [RL10]

  // Strobes only reach a decoded subaddress; others are dropped
  assign ser0_sub_wr_o = bus_wr_i & hit_s0_dat & s0_ok; // [RL3] [RL11]
  assign ser0_sub_rd_o = bus_rd_i & hit_s0_dat & s0_ok; // [RL3]
  assign ser1_sub_wr_o = bus_wr_i & hit_s1_dat & s1_ok; // [RL3] [RL11]
  assign ser1_sub_rd_o = bus_rd_i & hit_s1_dat & s1_ok; // [RL3]
  assign dma_sub_wr_o  = bus_wr_i & hit_d_dat & d_ok; // [RL7] [RL8] [RL11]
  assign dma_sub_rd_o  = bus_rd_i & hit_d_dat & d_ok; // [RL7] [RL8]

  // ****************************************************************
  // Direct DMA priority and enable control
  // ****************************************************************

  logic [15:0] prio_q;

  // Plain read/write register outside the subbank
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prio_q <= psr_pkg::PRIO_CTRL_RESET;
    end else if (bus_wr_i && hit_prio) begin
      prio_q <= bus_wdata_i; // [RL5]
    end
  end

  assign dma_prio_ctrl_o = prio_q;

  // ****************************************************************
  // Read data return
  // ****************************************************************

  logic [15:0] rdata_d;
  logic [15:0] rdata_q;
  logic        rvalid_q;

  // Unmapped reads still answer, with zero, so the core never waits on them
  // Read mux; undecoded subaddresses and unmapped addresses give zero
  always_comb begin
    rdata_d = psr_pkg::RDATA_RESET;
    if (hit_s0_ptr) begin
      rdata_d = s0_ptr;
    end else if (hit_s1_ptr) begin
      rdata_d = s1_ptr;
    end else if (hit_d_ptr) begin
      rdata_d = d_ptr;
    end else if (hit_prio) begin
      rdata_d = prio_q;
    end else if (hit_s0_dat && s0_ok) begin
      rdata_d = ser0_sub_rdata_i; // [RL3]
    end else if (hit_s1_dat && s1_ok) begin
      rdata_d = ser1_sub_rdata_i; // [RL3]
    end else if (hit_d_dat && d_ok) begin
      rdata_d = dma_sub_rdata_i; // [RL7] [RL8]
    end else begin
      rdata_d = psr_pkg::RDATA_RESET; // [RL11]
    end
  end

  // Read data is captured on the clock edge that samples the read strobe and held until the next read
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= psr_pkg::RDATA_RESET;
    end else if (bus_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  // Read valid pulse
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rvalid_q <= 1'h0;
    end else begin
      rvalid_q <= bus_rd_i;
    end
  end

  assign bus_rdata_o  = rdata_q;
  assign bus_rvalid_o = rvalid_q;

endmodule
`default_nettype wire

//--- verif/psr_periph_model.sv
// Register files of both serial ports and the DMA controller
`default_nettype none
module psr_periph_model (
  // Clock and shared write data
  input  wire logic        clk_i,
  input  wire logic [15:0] wdata_i,
  // Serial port register files
  input  wire logic [3:0]  s0_addr_i,
  input  wire logic        s0_wr_i,
  output logic      [15:0] s0_rdata_o,
  input  wire logic [3:0]  s1_addr_i,
  input  wire logic        s1_wr_i,
  output logic      [15:0] s1_rdata_o,
  // DMA register file
  input  wire logic [5:0]  d_addr_i,
  input  wire logic        d_wr_i,
  output logic      [15:0] d_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] s0_q [16];
  logic [15:0] s1_q [16];
  logic [15:0] d_q  [64];
  // Read data follows the pointer in the same cycle
  assign s0_rdata_o = s0_q[s0_addr_i];
  assign s1_rdata_o = s1_q[s1_addr_i];
  assign d_rdata_o  = d_q[d_addr_i];
  // Store on each one-cycle write strobe
  always_ff @(posedge clk_i) begin
    if (s0_wr_i) s0_q[s0_addr_i] <= wdata_i;
    if (s1_wr_i) s1_q[s1_addr_i] <= wdata_i;
    if (d_wr_i) d_q[d_addr_i] <= wdata_i;
  end
endmodule
`default_nettype wire

//--- verif/psr_top_monitor.sv
// Checker of the bus decode and subbank pointer behaviour
`default_nettype none
module psr_top_monitor (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // Bus and block outputs
  input wire logic [15:0] bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic        bus_wr_i,
  input wire logic        bus_rd_i,
  input wire logic        bus_hit_o,
  input wire logic        bus_rvalid_o,
  input wire logic [3:0]  ser0_sub_addr_o,
  input wire logic        ser0_sub_wr_o,
  input wire logic [3:0]  ser1_sub_addr_o,
  input wire logic        ser1_sub_wr_o,
  input wire logic [5:0]  dma_sub_addr_o,
  input wire logic        dma_sub_wr_o,
  input wire logic [15:0] dma_prio_ctrl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic acc;
  // Any bus request
  assign acc = bus_wr_i | bus_rd_i;
  a_core_no_hit: assert property (acc && bus_addr_i <= 16'h001F |-> !bus_hit_o)
    else $error("core address claimed");
  a_read_pulse: assert property (1'b1 |=> bus_rvalid_o == $past(bus_rd_i))
    else $error("read answer timing wrong");
  a_ser0_route: assert property (ser0_sub_wr_o |-> bus_wr_i && bus_addr_i == 16'h0039)
    else $error("serial0 strobe without data write");
  a_ser0_ptr_load: assert property (bus_wr_i && bus_addr_i == 16'h0038 |=>
    ser0_sub_addr_o == 4'($past(bus_wdata_i)))
    else $error("serial0 pointer not loaded");
  a_ser1_ptr_load: assert property (bus_wr_i && bus_addr_i == 16'h0048 |=>
    ser1_sub_addr_o == 4'($past(bus_wdata_i)))
    else $error("serial1 pointer not loaded");
  a_dma_fix_hold: assert property (acc && bus_addr_i == 16'h0057 |=> $stable(dma_sub_addr_o))
    else $error("fixed port moved the pointer");
  a_dma_inc_step: assert property (acc && bus_addr_i == 16'h0056 |=>
    dma_sub_addr_o == $past(dma_sub_addr_o) + 6'h01)
    else $error("autoinc port did not step");
  a_dma_range: assert property (dma_sub_wr_o |->
    bus_wr_i && bus_addr_i[15:1] == 15'h002B && dma_sub_addr_o <= 6'h27)
    else $error("dma strobe outside decoded range");
  a_prio_load: assert property (bus_wr_i && bus_addr_i == 16'h0054 |=> dma_prio_ctrl_o == $past(bus_wdata_i))
    else $error("priority control not loaded");
  c_dma_run: cover property (dma_sub_wr_o ##1 dma_sub_wr_o);
  c_ser1_wr: cover property (ser1_sub_wr_o);
  c_unmapped: cover property (acc && !bus_hit_o);
endmodule
bind psr_top psr_top_monitor mon_u (.*);
`default_nettype wire

//--- verif/psr_top_tb.sv
// Self-checking bench for the peripheral subbank register access block
`default_nettype none
module psr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i = 0, reset_n_i = 0, bus_wr_i = 0, bus_rd_i = 0;
  logic [15:0] bus_addr_i = '0, bus_wdata_i = '0, v, pa;
  logic        bus_hit_o, bus_rvalid_o, s0w, s0r, s1w, s1r, dw, dr;
  logic [15:0] bus_rdata_o, pwd, s0d, s1d, dd, prio;
  logic [3:0]  s0a, s1a;
  logic [5:0]  da;
  int          bad_count = 0, checks = 0;
  logic [31:0] seed = 32'd99252;
  logic [15:0] exp_q[$];
  logic [15:0] ser_m [2][16];
  logic [15:0] dma_m [40];
  // Shadow pointers of serial 0, serial 1 and DMA, at their reset value
  logic [15:0] sp [3] = '{16'h0000, 16'h0000, 16'h0000};
  logic [15:0] rl [6] = '{16'h0038, 16'h0048, 16'h0055, 16'h0054, 16'h0010, 16'h003A};
  psr_top dut_u (.clk_i, .reset_n_i, .bus_addr_i, .bus_wdata_i, .bus_wr_i, .bus_rd_i, .bus_hit_o,
    .bus_rdata_o, .bus_rvalid_o, .per_wdata_o(pwd), .ser0_sub_addr_o(s0a), .ser0_sub_wr_o(s0w),
    .ser0_sub_rd_o(s0r), .ser0_sub_rdata_i(s0d), .ser1_sub_addr_o(s1a), .ser1_sub_wr_o(s1w),
    .ser1_sub_rd_o(s1r), .ser1_sub_rdata_i(s1d), .dma_sub_addr_o(da), .dma_sub_wr_o(dw),
    .dma_sub_rd_o(dr), .dma_sub_rdata_i(dd), .dma_prio_ctrl_o(prio));
  psr_periph_model pm_u (.clk_i, .wdata_i(pwd), .s0_addr_i(s0a), .s0_wr_i(s0w), .s0_rdata_o(s0d),
    .s1_addr_i(s1a), .s1_wr_i(s1w), .s1_rdata_o(s1d), .d_addr_i(da), .d_wr_i(dw), .d_rdata_o(dd));
  // Clock at 100 ns period
  always #50 clk_i = ~clk_i;
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // One bus cycle, launched just after the rising edge
  task automatic op(logic w, logic r, logic [15:0] a, logic [15:0] d);
    logic [15:0] eh;
    logic [2:0]  es;
    bus_wr_i = w;
    bus_rd_i = r;
    bus_addr_i = a;
    bus_wdata_i = d;
    eh = 16'(a inside {[16'h0054:16'h0057], 16'h0038, 16'h0039, 16'h0048, 16'h0049});
    es = {a == 16'h0039 && sp[0] <= 16'h000E, a == 16'h0049 && sp[1] <= 16'h000E,
          a[15:1] == 15'h002B && sp[2] <= 16'h0027};
    #1;
    if (w | r) chk("hit", eh, 16'(bus_hit_o));
    chk("wr strobes", 16'(es & {3{w}}), 16'({s0w, s1w, dw}));
    chk("rd strobes", 16'(es & {3{r}}), 16'({s0r, s1r, dr}));
    if (w && a == 16'h0038) sp[0] = d;
    if (w && a == 16'h0048) sp[1] = d;
    if (w && a == 16'h0055) sp[2] = d;
    if ((w | r) && a == 16'h0056) sp[2] = sp[2] + 16'h0001;
    @(posedge clk_i);
    #1;
  endtask
  task automatic wr(logic [15:0] a, logic [15:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(logic [15:0] a, logic [15:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read answers are matched against the oldest note
  always @(negedge clk_i) begin
    if (bus_rvalid_o === 1'b1) begin
      if (exp_q.size() == 0) chk("rvalid", 16'h0000, 16'h0001);
      else chk("rdata", exp_q.pop_front(), bus_rdata_o);
    end
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    report_and_stop();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (6) @(posedge clk_i);
    #1;
    reset_n_i = 1;
    foreach (rl[i]) rd(rl[i], 16'h0000);
    $display("test reset map done");
    for (int p = 0; p < 2; p++) begin
      pa = p ? 16'h0048 : 16'h0038;
      for (int s = 0; s < 16; s++) begin
        v = rnd();
        wr(pa, 16'(s));
        wr(pa + 16'h0001, v);
        if (s < 15) ser_m[p][s] = v;
      end
      wr(pa, 16'h0103);
      wr(pa + 16'h0001, 16'hFFFF);
      rd(pa, 16'h0103);
    end
    for (int p = 0; p < 2; p++) begin
      pa = p ? 16'h0048 : 16'h0038;
      for (int s = 0; s < 16; s++) begin
        wr(pa, 16'(s));
        rd(pa + 16'h0001, s < 15 ? ser_m[p][s] : 16'h0000);
      end
    end
    $display("test serial done");
    wr(16'h0055, 16'h0000);
    for (int s = 0; s < 40; s++) begin
      dma_m[s] = rnd();
      wr(16'h0056, dma_m[s]);
    end
    wr(16'h0056, 16'h1234);
    rd(16'h0055, 16'h0029);
    wr(16'h0055, 16'h0000);
    for (int s = 0; s < 40; s++) rd(16'h0056, dma_m[s]);
    rd(16'h0057, 16'h0000);
    wr(16'h0055, 16'h0005);
    rd(16'h0057, dma_m[5]);
    wr(16'h0057, 16'hA5A5);
    rd(16'h0057, 16'hA5A5);
    rd(16'h0055, 16'h0005);
    $display("test dma done");
    v = rnd();
    wr(16'h0054, v);
    rd(16'h0054, v);
    rd(16'h0055, 16'h0005);
    op(1'b0, 1'b0, 16'h0000, 16'h0000);
    chk("prio", v, prio);
    repeat (3) @(posedge clk_i);
    chk("pending", 16'h0000, 16'(exp_q.size()));
    $display("test prio done");
    report_and_stop();
  end
endmodule
`default_nettype wire
